// ===== src/ttlfc_pkg.sv
// Constants for the thermal timer, limit and fan configuration bank.
// Assumes a 20 MHz clock and registers reached one per aligned AHB word.
package ttlfc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CFG_LOCK    = 8'h40;
  localparam logic [7:0] IDX_INT_STATUS2 = 8'h42;
  localparam logic [7:0] IDX_INT_MASK2   = 8'h75;
  localparam logic [7:0] IDX_CFG_MONITOR = 8'h78;
  localparam logic [7:0] IDX_THERM_STAT  = 8'h79;
  localparam logic [7:0] IDX_LIMIT       = 8'h7A;
  localparam logic [7:0] IDX_PULSES      = 8'h7B;
  localparam logic [7:0] IDX_PIN_CFG     = 8'h7D;
  localparam logic [7:0] IDX_TEST_A      = 8'h7E;
  localparam logic [7:0] IDX_TEST_B      = 8'h7F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LOCK_BIT       = 0;
  localparam int TIMER_EVT_BIT  = 5;
  localparam int THERM_EN_BIT   = 1;
  localparam int ALERT_SEL_BIT  = 0;
  localparam int OTP_SEL_BIT    = 1;
  localparam int THRESH_LSB     = 2;
  localparam int PULSE_FLD_W    = 2;
  localparam int FAN_COUNT      = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LIMIT   = 8'h00;
  localparam logic [7:0] RST_PULSES  = 8'h55;
  localparam logic [3:0] RST_PIN_CFG = 4'h0;
  localparam logic [7:0] RST_MASK2   = 8'h00;
  localparam logic [7:0] RST_CFG_MON = 8'h00;
  // Factory test contents, arbitrary values
  localparam logic [7:0] RST_TEST_A  = 8'h00;
  localparam logic [7:0] RST_TEST_B  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_NS       = 22760000;  // 22.76 ms per count
  localparam int STEP_CYCLES   = STEP_NS / CLK_PERIOD_NS;

  // Two-wire threshold in mV per code
  localparam logic [7:0] THR_MV_0 = 8'd20;
  localparam logic [7:0] THR_MV_1 = 8'd40;
  localparam logic [7:0] THR_MV_2 = 8'd80;
  localparam logic [7:0] THR_MV_3 = 8'd130;

endpackage

// ===== src/ttlfc_if.sv
// Interfaces between the bus front end, register bank and timer.
// Assumes all parties run on the one block clock.
`timescale 1ns/1ps
`default_nettype none

interface ttlfc_reg_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus  (output wr_stb, rd_stb, idx, wdata, input rdata);
  modport regs (input wr_stb, rd_stb, idx, wdata, output rdata);
endinterface

interface ttlfc_tmr_if;
  logic       active;
  logic [7:0] limit;
  logic       rd_clear;
  logic [7:0] value;
  logic       event_p;
  modport tmr (input active, limit, rd_clear, output value, event_p);
  modport ctl (output active, limit, rd_clear, input value, event_p);
endinterface

`default_nettype wire

// ===== src/ttlfc_ahb_slave.sv
// AHB-Lite slave front end: turns transfers into register strobes.
// Assumes single word transfers; reads take one wait state.
`timescale 1ns/1ps
`default_nettype none

module ttlfc_ahb_slave
  import ttlfc_pkg::*;
(
  input  wire logic        clock_i,     // Block clock
  input  wire logic        rst_b_i,     // Async reset, active low
  input  wire logic        hsel_i,      // Slave select
  input  wire logic [31:0] haddr_i,     // Address
  input  wire logic [1:0]  htrans_i,    // Transfer type
  input  wire logic        hwrite_i,    // Write when high
  input  wire logic [2:0]  hsize_i,     // Transfer size
  input  wire logic        hready_i,    // Bus ready
  input  wire logic [31:0] hwdata_i,    // Write data
  output logic      [31:0] hrdata_o,    // Read data
  output logic             hreadyout_o, // Slave ready
  output logic             hresp_o,     // Response, always OKAY
  ttlfc_reg_if.bus         rif          // Register strobes
);

  logic       accept;
  logic       hit;
  logic       wr_pend;
  logic       rd_wait;
  logic       hit_q;
  logic [7:0] idx_q;

  assign accept = hsel_i & htrans_i[1] & hready_i;
  assign hit    = (haddr_i[31:10] == 22'h0) & (haddr_i[1:0] == 2'h0)
                  & (hsize_i == 3'h2);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      hit_q   <= 1'b0;
      idx_q   <= 8'h00;
    end else begin
      wr_pend <= accept & hwrite_i;
      rd_wait <= accept & ~hwrite_i;
      if (accept) begin
        hit_q <= hit;
        idx_q <= haddr_i[9:2];
      end
    end
  end

  // Read data captured in the wait state, after any prior write
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0;
    end else if (rd_wait) begin
      hrdata_o <= hit_q ? {24'h0, rif.rdata} : 32'h0;
    end
  end

  assign rif.wr_stb  = wr_pend & hit_q;
  assign rif.rd_stb  = rd_wait & hit_q;
  assign rif.idx     = idx_q;
  assign rif.wdata   = hwdata_i[7:0];
  assign hreadyout_o = ~rd_wait;
  assign hresp_o     = 1'b0;

endmodule

`default_nettype wire

// ===== src/ttlfc_assert_timer.sv
// Over-temperature assertion timer and limit comparator.
// Assumes a synchronised, already selected active level at its input.
`timescale 1ns/1ps
`default_nettype none

module ttlfc_assert_timer
  import ttlfc_pkg::*;
#(
  parameter int STEP = STEP_CYCLES
)(
  input  wire logic clock_i, // Block clock
  input  wire logic rst_b_i, // Async reset, active low
  ttlfc_tmr_if.tmr  tif      // Timer link
);

  localparam int DW = $clog2(STEP + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(STEP - 1);

  logic          active_d;
  logic          rise;
  logic          tick;
  logic          fired;
  logic          flag;
  logic [DW-1:0] div;
  logic [7:0]    count;
  logic [7:0]    count_inc;

  assign rise      = tif.active & ~active_d;
  assign tick      = tif.active & (div == DIV_LAST);
  assign count_inc = (count == 8'hFF) ? count : count + 8'h01;

  // ----------------------------------------------------------------
  // Step divider
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active_d <= 1'b0;
      div      <= '0;
    end else begin
      active_d <= tif.active;
      if (!tif.active || tick) begin
        div <= '0;
      end else begin
        div <= div + DW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulated time and assertion flag, cleared by a read
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= 8'h00;
      flag  <= 1'b0;
    end else begin
      flag <= rise | (flag & ~tif.rd_clear);
      if (tif.rd_clear) begin
        count <= tick ? 8'h01 : 8'h00;
      end else if (tick) begin
        count <= count_inc;
      end
    end
  end

  // Upper seven bits show zero and bit 0 shows the flag until two steps have passed
  assign tif.value = (count >= 8'h02) ? count : {7'h00, flag};

  // ----------------------------------------------------------------
  // Limit comparison, one event per assertion
  // ----------------------------------------------------------------
  always_comb begin
    if (tif.limit == 8'h00) begin
      tif.event_p = rise & ~fired;
    end else begin
      tif.event_p = tick & (count_inc > tif.limit) & ~fired;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fired <= 1'b0;
    end else if (!tif.active) begin
      fired <= 1'b0;
    end else if (tif.event_p) begin
      fired <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ===== src/ttlfc_bank.sv
// Thermal timer limit, fan pulse count and pin function registers.
// Assumes an AHB-Lite master and asynchronous, active-low pins.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ttlfc_bank
  import ttlfc_pkg::*;
#(
  parameter int STEP = STEP_CYCLES
)(
  input  wire logic        clock_i,        // Block clock
  input  wire logic        rst_b_i,        // Async reset, active low
  input  wire logic        hsel_i,         // AHB select
  input  wire logic [31:0] haddr_i,        // AHB address
  input  wire logic [1:0]  htrans_i,       // AHB transfer type
  input  wire logic        hwrite_i,       // AHB write
  input  wire logic [2:0]  hsize_i,        // AHB size
  input  wire logic        hready_i,       // AHB ready in
  input  wire logic [31:0] hwdata_i,       // AHB write data
  output logic      [31:0] hrdata_o,       // AHB read data
  output logic             hreadyout_o,    // AHB ready out
  output logic             hresp_o,        // AHB response
  input  wire logic        overtemp_5v_b_i,// Shared 5 V pin, low active
  input  wire logic        fourth_tach_b_i,// Fourth tach pin, low active
  output logic             meas_5v_en_o,   // 5 V pin measures voltage
  output logic             meas_2v5_en_o,  // 2.5 V pin measures voltage
  output logic             alert_pin_o,    // Alert pin data, always low
  output logic             alert_pin_oe_b_o, // Alert drive, low drives
  output logic [3:0][2:0]  fan_pulses_o,   // Pulses per fan, 1..4
  output logic [7:0]       tach_thresh_mv_o, // Two-wire threshold, mV
  output logic             irq_o           // Level interrupt
);

  ttlfc_reg_if rif ();
  ttlfc_tmr_if tif ();

  logic       otemp_5v_m;
  logic       otemp_5v_s;
  logic       fourth_tach_pin_m;
  logic       fourth_tach_pin_s;
  logic       lock;
  logic [7:0] int_status2;
  logic [7:0] int_mask2;
  logic [7:0] cfg_monitor;
  logic [7:0] assertion_limit_value;
  logic [7:0] tach_pulses_per_measurement;
  logic [3:0] pin_function_config;
  logic       low_supply_alert_select;
  logic       overtemp_pin_select;
  logic [1:0] two_wire_tach_threshold;
  logic       wr_limit;
  logic       wr_pulses;
  logic       wr_pincfg;
  logic       wr_cfg_mon;
  logic       wr_mask;
  logic       wr_status;
  logic       wr_lock;

  // ----------------------------------------------------------------
  // Bus front end and timer
  // ----------------------------------------------------------------
  ttlfc_ahb_slave u_ahb (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hready_i    (hready_i),
    .hwdata_i    (hwdata_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .rif         (rif.bus)
  );

  ttlfc_assert_timer #(
    .STEP (STEP)
  ) u_timer (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tif     (tif.tmr)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      otemp_5v_m <= 1'b1;
      otemp_5v_s <= 1'b1;
      fourth_tach_pin_m    <= 1'b1;
      fourth_tach_pin_s    <= 1'b1;
    end else begin
      otemp_5v_m <= overtemp_5v_b_i;
      otemp_5v_s <= otemp_5v_m;
      fourth_tach_pin_m    <= fourth_tach_b_i;
      fourth_tach_pin_s    <= fourth_tach_pin_m;
    end
  end

  assign low_supply_alert_select = pin_function_config[ALERT_SEL_BIT];
  assign overtemp_pin_select     = pin_function_config[OTP_SEL_BIT];
  assign two_wire_tach_threshold =
    pin_function_config[THRESH_LSB +: 2];

  // Input source follows pin select; monitoring needs the enable bit
  assign tif.active = cfg_monitor[THERM_EN_BIT] &
    (overtemp_pin_select ? ~otemp_5v_s : ~fourth_tach_pin_s);
  assign tif.limit    = assertion_limit_value;
  assign tif.rd_clear = rif.rd_stb & (rif.idx == IDX_THERM_STAT);

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_limit   = rif.wr_stb & (rif.idx == IDX_LIMIT);
  assign wr_pulses  = rif.wr_stb & (rif.idx == IDX_PULSES);
  assign wr_pincfg  = rif.wr_stb & (rif.idx == IDX_PIN_CFG);
  assign wr_cfg_mon = rif.wr_stb & (rif.idx == IDX_CFG_MONITOR);
  assign wr_mask    = rif.wr_stb & (rif.idx == IDX_INT_MASK2);
  assign wr_status  = rif.wr_stb & (rif.idx == IDX_INT_STATUS2);
  assign wr_lock    = rif.wr_stb & (rif.idx == IDX_CFG_LOCK);

  // ----------------------------------------------------------------
  // Lock, held until reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock <= 1'b0;
    end else if (wr_lock && rif.wdata[LOCK_BIT]) begin
      lock <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Limit and fan pulse registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      assertion_limit_value <= RST_LIMIT;
    end else if (wr_limit) begin
      assertion_limit_value <= rif.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tach_pulses_per_measurement <= RST_PULSES;
    end else if (wr_pulses) begin
      tach_pulses_per_measurement <= rif.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Lockable configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_function_config <= RST_PIN_CFG;
    end else if (wr_pincfg && !lock) begin
      pin_function_config <= rif.wdata[3:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_monitor <= RST_CFG_MON;
    end else if (wr_cfg_mon && !lock) begin
      cfg_monitor <= rif.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_mask2 <= RST_MASK2;
    end else if (wr_mask) begin
      int_mask2 <= rif.wdata;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_status2 <= 8'h00;
    end else if (tif.event_p) begin
      int_status2[TIMER_EVT_BIT] <= 1'b1;
    end else if (wr_status && rif.wdata[TIMER_EVT_BIT]) begin
      int_status2[TIMER_EVT_BIT] <= 1'b0;
    end
  end

  assign irq_o = int_status2[TIMER_EVT_BIT]
               & ~int_mask2[TIMER_EVT_BIT];

  // ----------------------------------------------------------------
  // Pin functions
  // ----------------------------------------------------------------
  assign meas_5v_en_o     = ~overtemp_pin_select;
  assign meas_2v5_en_o    = ~low_supply_alert_select;
  assign alert_pin_o      = 1'b0;
  assign alert_pin_oe_b_o = ~(low_supply_alert_select & irq_o);

  // ----------------------------------------------------------------
  // Fan pulse counts and threshold
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < FAN_COUNT; g++) begin : g_fan
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          fan_pulses_o[g] <= 3'h2;
        end else begin
          fan_pulses_o[g] <= {1'b0,
            tach_pulses_per_measurement[g*PULSE_FLD_W +: PULSE_FLD_W]}
            + 3'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tach_thresh_mv_o <= THR_MV_0;
    end else begin
      unique case (two_wire_tach_threshold)
        2'h0: tach_thresh_mv_o <= THR_MV_0;
        2'h1: tach_thresh_mv_o <= THR_MV_1;
        2'h2: tach_thresh_mv_o <= THR_MV_2;
        2'h3: tach_thresh_mv_o <= THR_MV_3;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (rif.idx)
      IDX_CFG_LOCK:    rif.rdata = {7'h00, lock};
      IDX_INT_STATUS2: rif.rdata = int_status2;
      IDX_INT_MASK2:   rif.rdata = int_mask2;
      IDX_CFG_MONITOR: rif.rdata = cfg_monitor;
      IDX_THERM_STAT:  rif.rdata = tif.value;
      IDX_LIMIT:       rif.rdata = assertion_limit_value;
      IDX_PULSES:      rif.rdata = tach_pulses_per_measurement;
      IDX_PIN_CFG:     rif.rdata = {4'h0, pin_function_config};
      IDX_TEST_A:      rif.rdata = RST_TEST_A;
      IDX_TEST_B:      rif.rdata = RST_TEST_B;
      default:         rif.rdata = 8'h00;
    endcase
  end

endmodule

`default_nettype wire

// ===== tb/ttlfc_therm_src.sv
// Far-side over-temperature source driving the two shared pins.
// Assumes pins have pull-ups: a released pin reads high.
`timescale 1ns/1ps
`default_nettype none
module ttlfc_therm_src (
  input  wire logic [1:0] assert_i, // Bit0 5 V pin, bit1 tach pin
  output logic            otp_b_o,  // Shared 5 V pin, low active
  output logic            tach_b_o  // Fourth tach pin, low active
);
  assign otp_b_o  = !assert_i[0];
  assign tach_b_o = !assert_i[1];
endmodule
`default_nettype wire

// ===== tb/ttlfc_bank_checker.sv
// Port-level assertions for the thermal limit and fan config bank.
// Assumes hready is looped back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module ttlfc_bank_checker (
  input wire logic            clock_i,          // Block clock
  input wire logic            rst_b_i,          // Reset, active low
  input wire logic            hsel_i,           // AHB select
  input wire logic [1:0]      htrans_i,         // AHB transfer type
  input wire logic            hwrite_i,         // AHB write
  input wire logic            hready_i,         // AHB ready in
  input wire logic            hreadyout_o,      // AHB ready out
  input wire logic            overtemp_5v_b_i,  // 5 V pin, low active
  input wire logic            fourth_tach_b_i,  // Tach pin, low active
  input wire logic            meas_5v_en_o,     // 5 V measure enable
  input wire logic            meas_2v5_en_o,    // 2.5 V measure enable
  input wire logic            alert_pin_oe_b_o, // Alert drive, low drives
  input wire logic [3:0][2:0] fan_pulses_o,     // Pulses per fan
  input wire logic [7:0]      tach_thresh_mv_o, // Threshold in mV
  input wire logic            irq_o             // Level interrupt
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic       take;
  logic       wr_dp;
  logic [2:0] quiet;
  assign take = hsel_i && htrans_i[1] && hready_i;
  // Write data phase flag and cycles since a pin was low
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_dp <= 1'b0;
      quiet <= 3'h7;
    end else begin
      wr_dp <= take && hwrite_i;
      if (!overtemp_5v_b_i || !fourth_tach_b_i) begin
        quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
        quiet <= quiet + 3'h1;
      end
    end
  end
  alert_drive_a: assert property (
    alert_pin_oe_b_o == !(!meas_2v5_en_o && irq_o))
    else $error("alert drive wrong");
  thresh_code_a: assert property (
    tach_thresh_mv_o inside {8'h14, 8'h28, 8'h50, 8'h82})
    else $error("threshold not a legal value");
  fan_range_a: assert property (
    fan_pulses_o[0] inside {[3'h1:3'h4]} &&
    fan_pulses_o[1] inside {[3'h1:3'h4]} &&
    fan_pulses_o[2] inside {[3'h1:3'h4]} &&
    fan_pulses_o[3] inside {[3'h1:3'h4]})
    else $error("fan pulses out of range");
  flag_sticky_a: assert property ($fell(irq_o) |-> $past(wr_dp))
    else $error("interrupt dropped without a write");
  config_hold_a: assert property (
    $changed({meas_5v_en_o, meas_2v5_en_o}) |-> $past(wr_dp))
    else $error("pin function changed without a write");
  fans_hold_a: assert property (
    $changed({fan_pulses_o, tach_thresh_mv_o}) |-> $past(wr_dp, 2))
    else $error("fan config changed without a write");
  read_wait_a: assert property (
    take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  irq_cause_a: assert property (
    $rose(irq_o) |-> $past(wr_dp) || quiet < 3'h5)
    else $error("interrupt rose without cause");
endmodule
bind ttlfc_bank ttlfc_bank_checker chk_u (.clock_i, .rst_b_i, .hsel_i,
  .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .overtemp_5v_b_i,
  .fourth_tach_b_i, .meas_5v_en_o, .meas_2v5_en_o, .alert_pin_oe_b_o,
  .fan_pulses_o, .tach_thresh_mv_o, .irq_o);
`default_nettype wire

// ===== tb/test_thermal_timer_limit_fan_config.sv
// Self-checking bench for the thermal limit and fan config bank.
// Assumes the bound checker and a step of 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module test_thermal_timer_limit_fan_config;
  import ttlfc_pkg::*;
  logic            clock_i, rst_b_i, hwrite_i, hreadyout_o, hresp_o;
  logic            otp_b, tach_b, m5, m25, al, al_oe_b, irq;
  logic [1:0]      htrans_i, src;
  logic [31:0]     haddr_i, hwdata_i, hrdata_o, q;
  logic [3:0][2:0] fp;
  logic [7:0]      mv;
  int              errors, comparisons, n;
  ttlfc_bank #(.STEP(8)) dut_u (.clock_i, .rst_b_i, .hsel_i(1'b1), .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i,
    .hrdata_o, .hreadyout_o, .hresp_o, .overtemp_5v_b_i(otp_b),
    .fourth_tach_b_i(tach_b), .meas_5v_en_o(m5), .meas_2v5_en_o(m25),
    .alert_pin_o(al), .alert_pin_oe_b_o(al_oe_b), .fan_pulses_o(fp),
    .tach_thresh_mv_o(mv), .irq_o(irq));
  ttlfc_therm_src src_u (.assert_i(src), .otp_b_o(otp_b), .tach_b_o(tach_b));
  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, d);
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {22'h0, i, 2'h0};
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] i, d);
    bus(1'b1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, e, input string nm);
    bus(1'b0, i, 8'h00);
    chk(nm, q, {24'h0, e});
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(IDX_LIMIT, 8'h00, "limit");
    rd(IDX_PULSES, 8'h55, "pulses");
    rd(IDX_PIN_CFG, 8'h00, "pincfg");
    chk("fans", 32'(fp), 32'({4{3'h2}}));
    chk("meas", 32'({m5, m25}), 32'h3);
  endtask
  task automatic t_fans;
    wr(IDX_PULSES, 8'hE4);
    rd(IDX_PULSES, 8'hE4, "pulses");
    chk("fans", 32'(fp), 32'({3'h4, 3'h3, 3'h2, 3'h1}));
    wr(IDX_PULSES, 8'h1B);
    repeat (2) @(posedge clock_i);
    chk("fans", 32'(fp), 32'({3'h1, 3'h2, 3'h3, 3'h4}));
  endtask
  task automatic t_pin;
    logic [7:0] tbl [4] = '{8'h14, 8'h28, 8'h50, 8'h82};
    for (int c = 0; c < 4; c++) begin
      wr(IDX_PIN_CFG, 8'(c * 5));
      rd(IDX_PIN_CFG, 8'(c * 5), "pincfg");
      chk("thr", 32'(mv), 32'(tbl[c]));
      chk("meas", 32'({m5, m25}), 32'(~c & 3));
    end
  endtask
  task automatic t_ro;
    wr(IDX_TEST_A, 8'hFF);
    wr(IDX_TEST_B, 8'hA5);
    wr(8'h7C, 8'h3C);
    rd(IDX_TEST_A, 8'h00, "test_a");
    rd(IDX_TEST_B, 8'h00, "test_b");
    rd(8'h7C, 8'h00, "unmapped");
    chk("resp", 32'(hresp_o), 32'h0);
  endtask
  task automatic t_zero;
    wr(IDX_LIMIT, 8'h00);
    wr(IDX_CFG_MONITOR, 8'h02);
    wr(IDX_PIN_CFG, 8'h03);
    src <= 2'h1;
    wait_irq(20);
    chk("zero_lat", 32'(n <= 4), 32'h1);
    chk("alert", 32'(al_oe_b), 32'h0);
    chk("alert_d", 32'(al), 32'h0);
    src <= 2'h0;
    rd(IDX_INT_STATUS2, 8'h20, "status");
    rd(IDX_THERM_STAT, 8'h01, "asrt");
    chk("sticky", 32'(irq), 32'h1);
    wr(IDX_INT_STATUS2, 8'h20);
    @(posedge clock_i);
    chk("cleared", 32'(irq), 32'h0);
  endtask
  task automatic t_limit;
    wr(IDX_PIN_CFG, 8'h00);
    wr(IDX_LIMIT, 8'hFF);
    rd(IDX_LIMIT, 8'hFF, "limit_max");
    wr(IDX_LIMIT, 8'h03);
    bus(1'b0, IDX_THERM_STAT, 8'h00);
    src <= 2'h2;
    wait_irq(60);
    chk("lim_lat", 32'(n inside {[30:38]}), 32'h1);
    src <= 2'h0;
    rd(IDX_THERM_STAT, 8'h04, "timer");
    rd(IDX_THERM_STAT, 8'h00, "tstat");
    wr(IDX_INT_MASK2, 8'h20);
    @(posedge clock_i);
    chk("masked", 32'(irq), 32'h0);
    rd(IDX_INT_STATUS2, 8'h20, "status");
    wr(IDX_INT_MASK2, 8'h00);
    @(posedge clock_i);
    chk("unmasked", 32'(irq), 32'h1);
    wr(IDX_INT_STATUS2, 8'h20);
    rd(IDX_INT_STATUS2, 8'h00, "status");
  endtask
  task automatic t_lock;
    wr(IDX_PIN_CFG, 8'h06);
    wr(IDX_CFG_LOCK, 8'h01);
    wr(IDX_PIN_CFG, 8'h09);
    wr(IDX_CFG_MONITOR, 8'hFF);
    rd(IDX_PIN_CFG, 8'h06, "locked");
    rd(IDX_CFG_MONITOR, 8'h02, "locked");
    chk("thr", 32'(mv), 32'h28);
  endtask
  task automatic finish_test;
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    errors = 0;
    comparisons = 0;
    rst_b_i = 1'b0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    haddr_i = '0;
    hwdata_i = '0;
    src = 2'h0;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_fans();
    t_pin();
    t_ro();
    t_zero();
    t_limit();
    t_lock();
    finish_test();
  end
  initial begin
    repeat (4000) @(posedge clock_i);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
